// ### hw/gyro_sensor_register_bank.sv
// Purpose: register bank of an angular-rate sensor behind a serial port
// Assumes: link clock idles low, host leaves a gap of at least 8 core
//          cycles between frames, sensor core inputs are on clock_i
// Notes: every read returns a byte pair; response goes out one frame late
`timescale 1ns/1ns
`default_nettype none

// What this block does
// (RQ1) read returns addressed byte plus next byte
// (RQ2) response bits leave most significant first
// (RQ3) host reads pairs at even addresses only; the block answers odd addresses too
// (RQ4) bits 15:8 upper byte, 7:0 lower
// (RQ5) rate pair, two's complement, refreshed 500 Hz
// (RQ6) ten-bit temperature, low two bits on top
// (RQ7) filtered self-check out of limits raises fault
// (RQ8) raw self-check never raises the fault
// (RQ9) motion error pair refreshed at 250 Hz
// (RQ10) low flag byte appended to every response
// (RQ11) fault flags set well within 5 us
// (RQ12) flags stick until flag read or sensor command; a read at the motion error low byte also clears them
// (RQ13) persisting condition sets flag again at once
// (RQ14) flag bit layout of both flag bytes
// (RQ15) part version pair returns fixed code
// (RQ16) serial number read as two pairs
// (RQ17) null trim is the only writable pair
// (RQ18) check request forces faults, kind 10, decay
// (RQ19) supply fault set with high or low supply
// (RQ20) writes elsewhere are ignored
// (RQ21) unused bits read as zero
module gyro_sensor_register_bank
    import gyro_regs_pkg::*;
#(
    parameter int unsigned REFRESH_CYCLES = REFRESH_TICK_CYCLES,
    parameter int unsigned SETTLE_CYCLES = CHECK_SETTLE_CYCLES,
    parameter logic [15:0] PART_VERSION = 16'h0A0B, // arbitrary value
    parameter logic [31:0] SERIAL_ID = 32'hC0DE0001, // arbitrary value
    parameter logic signed [15:0] SELFCHECK_LIMIT_HI = 16'sh0640,
    parameter logic signed [15:0] SELFCHECK_LIMIT_LO = -16'sh0640
) (
    input wire logic clock_i,
    input wire logic reset_n_i,
    input wire logic spi_clk_i,
    input wire logic spi_cs_n_i,
    input wire logic spi_mosi_i,
    output logic spi_miso_o,
    output logic spi_miso_oe_o,
    input wire sensor_in_s sensor_i,
    input wire fault_cond_s fault_cond_i,
    output logic [9:0] null_trim_o,
    output logic check_active_o
);

    core_state_s s_reg;
    core_state_s s_next;
    link_state_s l_reg;
    link_state_s l_next;
    link_capture_s c_reg;
    link_capture_s c_next;
    logic link_rst_n;
    spi_frame_s frame;
    logic frame_ev;
    logic tick;
    logic fault_clear;
    logic filt_out;
    fault_s cond_all;
    logic [15:0] pair;
    logic [7:0] rd_addr;

    // upper flag byte, top four bits unused
    function automatic logic [7:0] flags_high(input fault_s f);
        flags_high = {4'h0, f.gross, f.resonator, f.supply_high,
            f.supply_low}; // see (RQ14)
    endfunction

    // lower flag byte, bit zero always zero
    function automatic logic [7:0] flags_low(input fault_s f);
        flags_low = {f.clock_lock, f.motion, f.memory, f.startup, f.supply,
            f.self_check, f.check_req, 1'b0}; // see (RQ14)
    endfunction

    // one eight-bit register by address; unmapped reads zero
    function automatic logic [7:0] reg_byte(input core_state_s cur,
        input logic [7:0] a);
        case (a)
            ADDR_ANGULAR_RATE_HIGH: reg_byte = cur.rate[15:8];
            ADDR_ANGULAR_RATE_LOW: reg_byte = cur.rate[7:0];
            ADDR_THERMAL_READING_HIGH: reg_byte = cur.thermal[9:2];
            ADDR_THERMAL_READING_LOW: reg_byte = {cur.thermal[1:0], 6'h00};
            ADDR_FILTERED_SELFCHECK_HIGH: reg_byte = cur.filt[15:8];
            ADDR_FILTERED_SELFCHECK_LOW: reg_byte = cur.filt[7:0];
            ADDR_RAW_SELFCHECK_HIGH: reg_byte = cur.raw[15:8];
            ADDR_RAW_SELFCHECK_LOW: reg_byte = cur.raw[7:0];
            ADDR_MOTION_ERROR_HIGH: reg_byte = cur.motion[15:8];
            ADDR_MOTION_ERROR_LOW: reg_byte = cur.motion[7:0];
            ADDR_ERROR_FLAGS_HIGH: reg_byte = flags_high(cur.flags);
            ADDR_ERROR_FLAGS_LOW: reg_byte = flags_low(cur.flags);
            ADDR_PART_VERSION_HIGH: reg_byte = PART_VERSION[15:8];
            ADDR_PART_VERSION_LOW: reg_byte = PART_VERSION[7:0]; // see (RQ15)
            ADDR_SERIAL_ID_BYTE3: reg_byte = SERIAL_ID[31:24];
            ADDR_SERIAL_ID_BYTE2: reg_byte = SERIAL_ID[23:16];
            ADDR_SERIAL_ID_BYTE1: reg_byte = SERIAL_ID[15:8];
            ADDR_SERIAL_ID_BYTE0: reg_byte = SERIAL_ID[7:0];
            ADDR_NULL_TRIM_HIGH: reg_byte = {6'h00, cur.trim[9:8]};
            ADDR_NULL_TRIM_LOW: reg_byte = cur.trim[7:0];
            default: reg_byte = 8'h00; // see (RQ21)
        endcase
    endfunction

    // ---------------- link clock domain ----------------

    // frame-scoped state is cleared while chip select is high
    assign link_rst_n = reset_n_i & ~spi_cs_n_i;

    // shift in on each rising edge, launch the next response bit
    always_comb begin
        l_next = l_reg;
        c_next = c_reg;
        if (l_reg.bit_cnt < 6'(FRAME_BITS)) begin
            l_next.bit_cnt = l_reg.bit_cnt + 6'h01;
            l_next.shift = {l_reg.shift[29:0], spi_mosi_i};
            l_next.oe = 1'b1;
            // response word is quiet during a frame, so sampled directly
            l_next.miso = s_reg.resp[5'(31 - l_reg.bit_cnt)]; // see (RQ2)
            if (l_reg.bit_cnt == 6'(FRAME_BITS - 1)) begin
                c_next.word = {l_reg.shift, spi_mosi_i};
                c_next.done_tgl = ~c_reg.done_tgl;
            end
        end
    end

    // link clock may stop between frames; chip select ends the frame
    always_ff @(posedge spi_clk_i or negedge link_rst_n) begin
        if (!link_rst_n) begin
            l_reg <= '0;
        end else begin
            l_reg <= l_next;
        end
    end

    // captured frame survives chip select so the core can read it
    always_ff @(posedge spi_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            c_reg <= '0;
        end else begin
            c_reg <= c_next;
        end
    end

    assign spi_miso_o = l_reg.miso;
    assign spi_miso_oe_o = l_reg.oe;

    // ---------------- core clock domain ----------------

    // frame event: toggle crossed, taken once stages two and three agree
    assign frame_ev = (s_reg.done_sync[1] == s_reg.done_sync[2]) &&
        (s_reg.done_sync[2] != s_reg.done_seen);
    assign frame = c_reg.word;
    assign tick = (s_reg.tick_cnt == 20'(REFRESH_CYCLES - 1));
    assign rd_addr = frame.addr;
    assign pair = {reg_byte(s_reg, rd_addr),
        reg_byte(s_reg, 8'(rd_addr + 8'h01))}; // see (RQ1) (RQ4)

    // only the filtered value is judged against the limits
    assign filt_out = ($signed(s_reg.filt) > SELFCHECK_LIMIT_HI) ||
        ($signed(s_reg.filt) < SELFCHECK_LIMIT_LO); // see (RQ7) (RQ8)

    // reading either flag byte, the motion error low byte, or any sensor command clears the flags
    assign fault_clear = frame_ev && ((frame.cmd == CMD_SENSOR) ||
        ((frame.cmd == CMD_READ) && ((rd_addr == ADDR_MOTION_ERROR_LOW) ||
        (rd_addr == ADDR_ERROR_FLAGS_HIGH) ||
        (rd_addr == ADDR_ERROR_FLAGS_LOW)))); // see (RQ12)

    // conditions, with every fault forced while a check is running
    always_comb begin
        cond_all.gross = fault_cond_i.gross | s_reg.check_active;
        cond_all.resonator = fault_cond_i.resonator | s_reg.check_active;
        cond_all.supply_high = fault_cond_i.supply_high | s_reg.check_active;
        cond_all.supply_low = fault_cond_i.supply_low | s_reg.check_active;
        cond_all.clock_lock = fault_cond_i.clock_lock | s_reg.check_active;
        cond_all.motion = fault_cond_i.motion | s_reg.check_active;
        cond_all.memory = fault_cond_i.memory | s_reg.check_active;
        cond_all.startup = fault_cond_i.startup | s_reg.check_active;
        cond_all.supply = cond_all.supply_high | cond_all.supply_low;
        cond_all.self_check = filt_out | s_reg.check_active; // see (RQ18)
        cond_all.check_req = s_reg.chk_held;
    end

    // next core state
    always_comb begin
        s_next = s_reg;
        s_next.done_sync = {s_reg.done_sync[1:0], c_reg.done_tgl};
        if (frame_ev) begin
            s_next.done_seen = s_reg.done_sync[2];
        end

        // one base tick per millisecond; slower pairs use the phase
        s_next.tick_cnt = tick ? 20'h00000 : s_reg.tick_cnt + 20'h00001;
        if (tick) begin
            s_next.phase = s_reg.phase + 2'h1;
            s_next.filt = sensor_i.filt; // see (RQ7)
            s_next.raw = sensor_i.raw; // see (RQ8)
            if (s_reg.phase[0]) begin
                // trim applied here; sum wraps, trim range is small
                s_next.rate = sensor_i.rate +
                    {{6{s_reg.trim[9]}}, s_reg.trim}; // see (RQ5) (RQ17)
                s_next.thermal = sensor_i.thermal; // see (RQ6)
            end
            if (s_reg.phase == 2'h3) begin
                s_next.motion = sensor_i.motion; // see (RQ9)
            end
        end

        // set wins over clear; a lasting condition re-sets at once
        s_next.flags = (fault_clear ? '0 : s_reg.flags) |
            cond_all; // see (RQ11) (RQ13)
        s_next.flags.supply = s_next.flags.supply |
            s_next.flags.supply_high | s_next.flags.supply_low; // see (RQ19)

        // check window: forcing lasts a settle time after release
        if (s_reg.decay_cnt != 20'h00000) begin
            s_next.decay_cnt = s_reg.decay_cnt - 20'h00001;
        end
        if (frame_ev && (frame.cmd == CMD_SENSOR)) begin
            s_next.chk_held = frame.check_req;
            if (s_reg.chk_held && !frame.check_req) begin
                s_next.decay_cnt = 20'(SETTLE_CYCLES); // see (RQ18)
            end
        end
        s_next.check_active = s_next.chk_held ||
            (s_next.decay_cnt != 20'h00000);

        // response for the next frame, flags as seen before clearing
        if (frame_ev) begin
            s_next.resp.spare = 6'h00;
            s_next.resp.flags = flags_low(s_reg.flags); // see (RQ10)
            if (s_reg.chk_held || (frame.cmd == CMD_SENSOR &&
                frame.check_req)) begin
                s_next.resp.kind = KIND_CHECK; // see (RQ18)
            end else if (s_reg.flags.gross) begin
                s_next.resp.kind = KIND_FAIL;
            end else begin
                s_next.resp.kind = KIND_OK;
            end
            case (frame.cmd)
                CMD_SENSOR: begin
                    s_next.resp.data = s_reg.rate;
                end
                CMD_READ: begin
                    s_next.resp.data = pair; // see (RQ1) (RQ16)
                end
                CMD_WRITE: begin
                    // only the trim pair accepts data
                    if (rd_addr == ADDR_NULL_TRIM_HIGH) begin
                        s_next.trim = frame.data[9:0]; // see (RQ17)
                    end
                    s_next.resp.data = {6'h00, s_next.trim}; // see (RQ20)
                end
                default: begin
                    s_next.resp.data = 16'h0000;
                end
            endcase
        end
    end

    // core state register
    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign null_trim_o = s_reg.trim;
    assign check_active_o = s_reg.check_active;

    // ---------------- assertions ----------------

    a_supply_joint_flag: assert property ( // see (RQ19)
        @(posedge clock_i) disable iff (!reset_n_i)
        (s_reg.flags.supply_high || s_reg.flags.supply_low)
            |-> s_reg.flags.supply)
        else $error("supply flag missing beside high or low supply flag");

    a_fault_set_fast: assert property ( // see (RQ11)
        @(posedge clock_i) disable iff (!reset_n_i)
        fault_cond_i.memory |=> s_reg.flags.memory)
        else $error("memory flag not set one cycle after its condition");

    a_fault_stays_set: assert property ( // see (RQ12)
        @(posedge clock_i) disable iff (!reset_n_i)
        (s_reg.flags.clock_lock && !fault_clear) |=> s_reg.flags.clock_lock)
        else $error("clock lock flag dropped without a clearing access");

    a_fault_reasserts_now: assert property ( // see (RQ13)
        @(posedge clock_i) disable iff (!reset_n_i)
        (fault_clear && fault_cond_i.motion) |=> s_reg.flags.motion)
        else $error("motion flag not re-set while condition persists");

    a_raw_never_faults: assert property ( // see (RQ8)
        @(posedge clock_i) disable iff (!reset_n_i)
        (!filt_out && !s_reg.check_active && !s_reg.flags.self_check)
            |=> !s_reg.flags.self_check)
        else $error("self-check flag set without filtered cause");

    a_filtered_sets_flag: assert property ( // see (RQ7)
        @(posedge clock_i) disable iff (!reset_n_i)
        filt_out |=> s_reg.flags.self_check)
        else $error("filtered self-check out of limits, flag not set");

    a_trim_write_only: assert property ( // see (RQ20)
        @(posedge clock_i) disable iff (!reset_n_i)
        $changed(s_reg.trim) |-> $past(frame_ev &&
            (frame.cmd == CMD_WRITE) && (rd_addr == ADDR_NULL_TRIM_HIGH)))
        else $error("trim changed without a trim write");

    a_flags_appended_low: assert property ( // see (RQ10)
        @(posedge clock_i) disable iff (!reset_n_i)
        frame_ev |=> (s_reg.resp.flags == flags_low($past(s_reg.flags))))
        else $error("response does not carry the low flag byte");

    a_version_pair_read: assert property ( // see (RQ15)
        @(posedge clock_i) disable iff (!reset_n_i)
        (frame_ev && (frame.cmd == CMD_READ) &&
            (rd_addr == ADDR_PART_VERSION_HIGH))
            |=> (s_reg.resp.data == PART_VERSION))
        else $error("part version read returned a wrong pair");

    a_serial_lower_half: assert property ( // see (RQ16)
        @(posedge clock_i) disable iff (!reset_n_i)
        (frame_ev && (frame.cmd == CMD_READ) &&
            (rd_addr == ADDR_SERIAL_ID_BYTE1))
            |=> (s_reg.resp.data == SERIAL_ID[15:0]))
        else $error("serial number lower half read wrong");

    a_thermal_pad_zero: assert property ( // see (RQ21)
        @(posedge clock_i) disable iff (!reset_n_i)
        (frame_ev && (frame.cmd == CMD_READ) &&
            (rd_addr == ADDR_THERMAL_READING_HIGH))
            |=> (s_reg.resp.data[5:0] == 6'h00))
        else $error("unused temperature bits not zero");

    a_check_kind_code: assert property ( // see (RQ18)
        @(posedge clock_i) disable iff (!reset_n_i)
        (frame_ev && s_reg.chk_held) |=> (s_reg.resp.kind == KIND_CHECK))
        else $error("check held but response kind is not check");

    a_miso_msb_first: assert property ( // see (RQ2)
        @(posedge spi_clk_i) disable iff (!link_rst_n)
        (l_reg.bit_cnt == 6'h00) |=> (spi_miso_o == $past(s_reg.resp[31])))
        else $error("first response bit is not the top bit");

    a_rate_pair_read: assert property ( // see (RQ5)
        @(posedge clock_i) disable iff (!reset_n_i)
        (frame_ev && (frame.cmd == CMD_READ) &&
            (rd_addr == ADDR_ANGULAR_RATE_HIGH))
            |=> (s_reg.resp.data == $past(s_reg.rate)))
        else $error("rate pair read returned a wrong value");

    a_check_forces_gross: assert property ( // see (RQ18)
        @(posedge clock_i) disable iff (!reset_n_i)
        s_reg.check_active |=> s_reg.flags.gross)
        else $error("gross flag not forced during a check");

endmodule // gyro_sensor_register_bank

`default_nettype wire

// ### common/gyro_regs_pkg.sv
// Purpose: shared constants and carriers for the rate-sensor register bank
// Assumes: 20 MHz core clock, 32-bit serial frames
// Notes: addresses are the byte addresses of the eight-bit registers
package gyro_regs_pkg;

    // core clock and derived cycle counts
    localparam int unsigned CLK_HZ = 20_000_000;
    localparam int unsigned SELFCHECK_REFRESH_HZ = 1000;
    localparam int unsigned REFRESH_TICK_CYCLES = CLK_HZ / SELFCHECK_REFRESH_HZ;
    localparam int unsigned CHECK_SETTLE_MS = 50;
    localparam int unsigned CHECK_SETTLE_CYCLES =
        (CLK_HZ / 1000) * CHECK_SETTLE_MS;
    localparam int unsigned FAULT_SET_US = 5;
    localparam int unsigned FAULT_SET_CYCLES = (CLK_HZ / 1_000_000) * FAULT_SET_US;
    localparam int unsigned FRAME_BITS = 32;

    // register addresses
    localparam logic [7:0] ADDR_ANGULAR_RATE_HIGH = 8'h00;
    localparam logic [7:0] ADDR_ANGULAR_RATE_LOW = 8'h01;
    localparam logic [7:0] ADDR_THERMAL_READING_HIGH = 8'h02;
    localparam logic [7:0] ADDR_THERMAL_READING_LOW = 8'h03;
    localparam logic [7:0] ADDR_FILTERED_SELFCHECK_HIGH = 8'h04;
    localparam logic [7:0] ADDR_FILTERED_SELFCHECK_LOW = 8'h05;
    localparam logic [7:0] ADDR_RAW_SELFCHECK_HIGH = 8'h06;
    localparam logic [7:0] ADDR_RAW_SELFCHECK_LOW = 8'h07;
    localparam logic [7:0] ADDR_MOTION_ERROR_HIGH = 8'h08;
    localparam logic [7:0] ADDR_MOTION_ERROR_LOW = 8'h09;
    localparam logic [7:0] ADDR_ERROR_FLAGS_HIGH = 8'h0A;
    localparam logic [7:0] ADDR_ERROR_FLAGS_LOW = 8'h0B;
    localparam logic [7:0] ADDR_PART_VERSION_HIGH = 8'h0C;
    localparam logic [7:0] ADDR_PART_VERSION_LOW = 8'h0D;
    localparam logic [7:0] ADDR_SERIAL_ID_BYTE3 = 8'h0E;
    localparam logic [7:0] ADDR_SERIAL_ID_BYTE2 = 8'h0F;
    localparam logic [7:0] ADDR_SERIAL_ID_BYTE1 = 8'h10;
    localparam logic [7:0] ADDR_SERIAL_ID_BYTE0 = 8'h11;
    localparam logic [7:0] ADDR_NULL_TRIM_HIGH = 8'h12;
    localparam logic [7:0] ADDR_NULL_TRIM_LOW = 8'h13;

    // response kind codes
    localparam logic [1:0] KIND_FAIL = 2'h0;
    localparam logic [1:0] KIND_OK = 2'h1;
    localparam logic [1:0] KIND_CHECK = 2'h2;

    typedef enum logic [2:0] {
        CMD_NONE = 3'b000,
        CMD_SENSOR = 3'b001,
        CMD_WRITE = 3'b010,
        CMD_READ = 3'b100
    } spi_cmd_e;

    // command frame, first bit on the wire is cmd[2]
    typedef struct packed {
        spi_cmd_e cmd;
        logic [7:0] addr;
        logic [15:0] data;
        logic [2:0] spare;
        logic check_req;
        logic parity;
    } spi_frame_s;

    // response frame, first bit on the wire is kind[1]
    typedef struct packed {
        logic [1:0] kind;
        logic [5:0] spare;
        logic [15:0] data;
        logic [7:0] flags;
    } resp_s;

    // fault conditions raised by the sensor core
    typedef struct packed {
        logic gross;
        logic resonator;
        logic supply_high;
        logic supply_low;
        logic clock_lock;
        logic motion;
        logic memory;
        logic startup;
    } fault_cond_s;

    // sticky error flags
    typedef struct packed {
        logic gross;
        logic resonator;
        logic supply_high;
        logic supply_low;
        logic clock_lock;
        logic motion;
        logic memory;
        logic startup;
        logic supply;
        logic self_check;
        logic check_req;
    } fault_s;

    // measurements from the sensor core
    typedef struct packed {
        logic [15:0] rate;
        logic [9:0] thermal;
        logic [15:0] filt;
        logic [15:0] raw;
        logic [15:0] motion;
    } sensor_in_s;

    // core-clock state of the register bank
    typedef struct packed {
        logic [2:0] done_sync;
        logic done_seen;
        logic [19:0] tick_cnt;
        logic [1:0] phase;
        logic [15:0] rate;
        logic [9:0] thermal;
        logic [15:0] filt;
        logic [15:0] raw;
        logic [15:0] motion;
        fault_s flags;
        logic [9:0] trim;
        logic chk_held;
        logic [19:0] decay_cnt;
        logic check_active;
        resp_s resp;
    } core_state_s;

    // link-clock state that lives only for one frame
    typedef struct packed {
        logic [5:0] bit_cnt;
        logic [30:0] shift;
        logic miso;
        logic oe;
    } link_state_s;

    // link-clock capture of a finished frame
    typedef struct packed {
        spi_frame_s word;
        logic done_tgl;
    } link_capture_s;

endpackage

// ### verification/spi_host_model.sv
// Purpose: serial host that frames commands and collects the answers
// Assumes: link clock idles low and runs only while the device is selected
// Notes: answer bits are sampled on the falling link edge
`timescale 1ns/1ns
`default_nettype none
module spi_host_model (
    input wire logic clock_i,
    input wire logic miso_i,
    input wire logic miso_oe_i,
    output logic sclk_o,
    output logic cs_n_o,
    output logic mosi_o
);
    // idle levels at time zero
    initial begin
        sclk_o = 1'b0;
        cs_n_o = 1'b1;
        mosi_o = 1'b0;
    end
    // one frame of 32 bits at a 6 ns link period
    task automatic xfer(input logic [31:0] cmd, output logic [31:0] resp);
        resp = 32'h0;
        @(posedge clock_i);
        #1 cs_n_o = 1'b0;
        for (int i = 31; i >= 0; i--) begin
            mosi_o = cmd[i];
            #3 sclk_o = 1'b1;
            #3 sclk_o = 1'b0;
            // an undriven answer bit becomes x so it never matches
            resp[i] = miso_oe_i ? miso_i : 1'bx;
        end
        #3 cs_n_o = 1'b1;
        mosi_o = ~mosi_o; // a released line must not keep its level
        repeat (10) @(posedge clock_i); // gap above the 8-cycle minimum
        #1; // return off the edge, like all other stimulus
    endtask
endmodule // spi_host_model
`default_nettype wire

// ### verification/tb_gyro_sensor_register_bank.sv
// Purpose: self-checking bench for the rate-sensor register bank
// Assumes: short refresh and settle counts so the run stays brief
// Notes: each read answer is collected with the frame that follows it
`timescale 1ns/1ns
`default_nettype none
module tb_gyro_sensor_register_bank
    import gyro_regs_pkg::*;
;
    localparam int unsigned SETTLE = 16;
    localparam logic [15:0] PART = 16'h1234; // arbitrary value
    localparam logic [31:0] SERIAL = 32'h89AB4567; // arbitrary value
    logic clock_i = 1'b0;
    logic reset_n_i = 1'b0;
    logic sclk, cs_n, mosi, miso, miso_oe, check_active;
    sensor_in_s sensor = '0;
    fault_cond_s cond = '0;
    fault_cond_s c;
    logic [9:0] trim_out;
    logic [9:0] trim = 10'h000;
    logic [15:0] lf = 16'h0056;
    logic [15:0] v;
    logic [3:0] fh = 4'h0;
    logic [7:0] fl = 8'h00;
    logic [31:0] resp;
    logic [1:0] kd;
    logic [15:0] lim [3] = '{16'h0640, 16'hF9C0, 16'h0641};
    int error_cnt = 0;
    int tests_run = 0;

    always #25 clock_i = ~clock_i;

    gyro_sensor_register_bank #(.REFRESH_CYCLES(8), .SETTLE_CYCLES(SETTLE),
        .PART_VERSION(PART), .SERIAL_ID(SERIAL)) gyro_sensor_register_bank_i (
        .clock_i(clock_i), .reset_n_i(reset_n_i), .spi_clk_i(sclk),
        .spi_cs_n_i(cs_n), .spi_mosi_i(mosi), .spi_miso_o(miso),
        .spi_miso_oe_o(miso_oe), .sensor_i(sensor), .fault_cond_i(cond),
        .null_trim_o(trim_out), .check_active_o(check_active));
    spi_host_model host_i (.clock_i(clock_i), .miso_i(miso),
        .miso_oe_i(miso_oe), .sclk_o(sclk), .cs_n_o(cs_n), .mosi_o(mosi));

    // next value of the 16-bit random sequence
    task automatic step(output logic [15:0] r);
        lf = {lf[14:0], lf[15] ^ lf[13] ^ lf[12] ^ lf[10]};
        r = lf;
    endtask
    // register image as the host should see it, byte 0x00 on top
    function automatic logic [167:0] image();
        return {sensor.rate + {{6{trim[9]}}, trim}, sensor.thermal, 6'h00,
            sensor.filt, sensor.raw, sensor.motion, 4'h0, fh, fl, PART,
            SERIAL, 6'h00, trim, 8'h00};
    endfunction
    // command word with odd parity over the frame
    function automatic logic [31:0] cw(spi_cmd_e k, logic [7:0] a,
        logic [15:0] d, logic chk);
        logic [31:0] w;
        w = {k, a, d, 3'b000, chk, 1'b0};
        return {w[31:1], ~^w[31:1]};
    endfunction
    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        tests_run++;
        if (seen !== want) begin
            error_cnt++;
            $display("BAD t=%0t seen=%h want=%h", $time, seen, want);
        end
    endtask
    // read one pair; the answer arrives with a following idle frame
    task automatic read_pair(input logic [7:0] a, input logic [1:0] kind);
        logic [167:0] img;
        img = image();
        host_i.xfer(cw(CMD_READ, a, 16'h0000, 1'b0), resp);
        host_i.xfer(cw(CMD_NONE, 8'h00, 16'h0000, 1'b0), resp);
        check(resp, {kind, 6'h00, img[167 - 8 * a -: 16], fl});
    endtask
    task automatic close_out();
        $display("checks %0d errors %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // watchdog, far beyond the expected run of some 100 us
    initial begin
        #1_000_000;
        error_cnt++;
        close_out();
    end

    // main sequence
    initial begin
        repeat (16) @(posedge clock_i);
        #1 reset_n_i = 1'b1;
        repeat (2) @(posedge clock_i);
        // trim write keeps only ten bits, a write elsewhere is dropped
        step(v);
        trim = v[9:0];
        host_i.xfer(cw(CMD_WRITE, ADDR_NULL_TRIM_HIGH, v, 1'b0), resp);
        host_i.xfer(cw(CMD_WRITE, ADDR_ANGULAR_RATE_HIGH, ~v, 1'b0), resp);
        check({22'h0, trim_out}, {22'h0, trim});
        // random readings, raw self-check far out of limits at first
        for (int r = 0; r < 2; r++) begin
            @(posedge clock_i);
            #1 step(sensor.rate);
            step(v);
            sensor.thermal = v[9:0];
            step(v);
            sensor.filt = {{6{v[9]}}, v[9:0]};
            step(sensor.raw);
            step(sensor.motion);
            if (r == 0) begin
                sensor.raw = 16'h7FFF;
            end
            repeat (80) @(posedge clock_i);
            // odd addresses too, on purpose; serial high then low
            for (int a = 0; a < 20; a++) begin
                read_pair(a[7:0], KIND_OK);
            end
        end
        // fault flags: released, held, and cleared by a sensor command
        for (int k = 0; k < 3; k++) begin
            step(v);
            c = fault_cond_s'(v[7:0]);
            @(posedge clock_i);
            #1 cond = c;
            repeat (3) @(posedge clock_i);
            #1 cond = (k == 1) ? c : '0;
            fh = {c.gross, c.resonator, c.supply_high, c.supply_low};
            fl = {c.clock_lock, c.motion, c.memory, c.startup,
                c.supply_high | c.supply_low, 3'b000};
            kd = c.gross ? KIND_FAIL : KIND_OK; // gross fault means failure
            if (k == 2) begin
                host_i.xfer(cw(CMD_SENSOR, 8'h00, 16'h0000, 1'b0), resp);
                host_i.xfer(cw(CMD_NONE, 8'h00, 16'h0000, 1'b0), resp);
                check({resp[31:30], resp[7:0]}, {kd, fl});
            end else begin
                read_pair(ADDR_ERROR_FLAGS_HIGH, kd);
            end
            if (k == 1) begin
                read_pair(ADDR_ERROR_FLAGS_HIGH, kd);
                cond = '0;
                read_pair(ADDR_ERROR_FLAGS_HIGH, kd);
            end
            fh = 4'h0;
            fl = 8'h00;
            read_pair(ADDR_ERROR_FLAGS_HIGH, KIND_OK);
        end
        // filtered self-check against both limits, strict compare
        foreach (lim[j]) begin
            @(posedge clock_i);
            #1 sensor.filt = lim[j];
            repeat (80) @(posedge clock_i);
            fl = (j == 2) ? 8'h04 : 8'h00;
            read_pair(ADDR_FILTERED_SELFCHECK_HIGH, KIND_OK);
        end
        // check request held, then released into its decay time
        host_i.xfer(cw(CMD_SENSOR, 8'h00, 16'h0000, 1'b1), resp);
        check({31'h0, check_active}, 32'h1);
        host_i.xfer(cw(CMD_SENSOR, 8'h00, 16'h0000, 1'b0), resp);
        check({30'h0, resp[31:30]}, {30'h0, KIND_CHECK});
        check({31'h0, check_active}, 32'h1);
        repeat (SETTLE + 10) @(posedge clock_i);
        check({31'h0, check_active}, 32'h0);
        close_out();
    end
endmodule // tb_gyro_sensor_register_bank
`default_nettype wire
